// ---- hwsg_pkg.sv ----
// Package for the hardware status group: register selects, bit positions and carriers.
package hwsg_pkg;

   localparam int HWSG_W = 16;

   // Register selects used by the status command port.
   typedef enum logic [2:0] {
      HWSG_SEL_COND = 3'h0,
      HWSG_SEL_RISE = 3'h1,
      HWSG_SEL_FALL = 3'h2,
      HWSG_SEL_EVNT = 3'h3,
      HWSG_SEL_MASK = 3'h4
   } hwsg_sel_t;

   // Condition bit positions.
   localparam int HWSG_B_RSVD     = 15;
   localparam int HWSG_B_RIC2     = 14;
   localparam int HWSG_B_RIC1     = 13;
   localparam int HWSG_B_DRES     = 12;
   localparam int HWSG_B_DLOW     = 11;
   localparam int HWSG_B_DMEAS    = 10;
   localparam int HWSG_B_DARM     = 9;
   localparam int HWSG_B_ENC_AUX  = 8;
   localparam int HWSG_B_ENC_INFO = 7;
   localparam int HWSG_B_COMM     = 6;
   localparam int HWSG_B_LIMIT    = 5;
   localparam int HWSG_B_SELFTEST = 4;
   localparam int HWSG_B_OVERPWR  = 3;
   localparam int HWSG_B_UNUSED   = 2;
   localparam int HWSG_B_MIKE     = 1;
   localparam int HWSG_B_BATT     = 0;

   // Reset values of the writable and latched registers.
   localparam logic [15:0] HWSG_RST_RISE = 16'hffff;
   localparam logic [15:0] HWSG_RST_FALL = 16'h0000;
   localparam logic [15:0] HWSG_RST_EVNT = 16'h0000;
   localparam logic [15:0] HWSG_RST_MASK = 16'h0000;
   localparam logic [15:0] HWSG_ZERO     = 16'h0000;

   // Raw hardware conditions gathered from the instrument.
   typedef struct packed {
      logic ric_int2;
      logic ric_int1;
      logic dec_results;
      logic dec_level_low;
      logic dec_measuring;
      logic dec_armed;
      logic enc_two_fields;
      logic enc_fields_sent_a;
      logic enc_fields_sent_b;
      logic enc_func_gen;
      logic comm_summary;
      logic limit_exceeded;
      logic selftest_failed;
      logic overpower;
      logic ext_mike_keyed;
      logic ext_batt_low;
   } hwsg_hw_in_t;

   // One status command from the remote controller.
   typedef struct packed {
      logic        valid;
      logic        write;
      hwsg_sel_t   sel;
      logic [15:0] wdata;
   } hwsg_cmd_t;

endpackage

// ---- hwsg_edge.sv ----
// Transition filter and event latch for the status group.
`timescale 1ns/100ps
`default_nettype none
module hwsg_edge
   import hwsg_pkg::*;
#(
   parameter int W = HWSG_W
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] cond,
   input  wire logic [W-1:0] rise_flt,
   input  wire logic [W-1:0] fall_flt,
   input  wire logic         clear,
   output logic      [W-1:0] event_q
);
   logic [W-1:0] cond_prev_ff;
   logic [W-1:0] event_ff;
   logic [W-1:0] nxt_event;
   wire  [W-1:0] hit;

   // Rising edges pass the rise filter, falling edges the fall filter.
   assign hit = (cond & ~cond_prev_ff & rise_flt)
              | (~cond & cond_prev_ff & fall_flt);
   // A hit in the clearing cycle survives, so no event is lost.
   assign nxt_event = (clear ? '0 : event_ff) | hit;
   assign event_q = event_ff;

   // Previous condition and event latch.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cond_prev_ff <= '0;
         event_ff     <= '0;
      end else if (clk_en) begin
         cond_prev_ff <= cond;
         event_ff     <= nxt_event;
      end
   end
endmodule
`default_nettype wire

// ---- hwsg_top.sv ----
// Top of the hardware status group: condition, filters, events, mask.
`timescale 1ns/100ps
`default_nettype none
module hwsg_top
   import hwsg_pkg::*;
#(
   parameter int W = HWSG_W
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic         clk_en,
   input  wire hwsg_hw_in_t  hw_in,
   input  wire hwsg_cmd_t    cmd,
   input  wire logic         clear_status,
   output logic [W-1:0]      rdata,
   output logic              rvalid,
   output logic              summary
);
   logic [W-1:0] cond_ff;
   logic [W-1:0] rise_ff;
   logic [W-1:0] fall_ff;
   logic [W-1:0] mask_ff;
   logic [W-1:0] rdata_ff;
   logic         rvalid_ff;
   logic [W-1:0] event_q;
   logic [W-1:0] nxt_cond;
   logic [W-1:0] nxt_rdata;

   // Encoder field decode; function generator mode blanks bit 7.
   wire both_sent = hw_in.enc_two_fields
                  & hw_in.enc_fields_sent_a
                  & hw_in.enc_fields_sent_b;
   wire one_sent  = hw_in.enc_two_fields
                  ? (hw_in.enc_fields_sent_a ^ hw_in.enc_fields_sent_b)
                  : hw_in.enc_fields_sent_a;
   wire info_bit  = one_sent & ~hw_in.enc_func_gen;

   // Condition assembly from raw hardware levels.
   always_comb begin
      nxt_cond                  = HWSG_ZERO;
      nxt_cond[HWSG_B_RSVD]     = 1'b0;
      nxt_cond[HWSG_B_RIC2]     = hw_in.ric_int2;
      nxt_cond[HWSG_B_RIC1]     = hw_in.ric_int1;
      nxt_cond[HWSG_B_DRES]     = hw_in.dec_results;
      nxt_cond[HWSG_B_DLOW]     = hw_in.dec_level_low;
      nxt_cond[HWSG_B_DMEAS]    = hw_in.dec_measuring;
      nxt_cond[HWSG_B_DARM]     = hw_in.dec_armed;
      nxt_cond[HWSG_B_ENC_AUX]  = both_sent;
      nxt_cond[HWSG_B_ENC_INFO] = info_bit;
      nxt_cond[HWSG_B_COMM]     = hw_in.comm_summary;
      nxt_cond[HWSG_B_LIMIT]    = hw_in.limit_exceeded;
      nxt_cond[HWSG_B_SELFTEST] = hw_in.selftest_failed;
      nxt_cond[HWSG_B_OVERPWR]  = hw_in.overpower;
      nxt_cond[HWSG_B_UNUSED]   = 1'b0;
      nxt_cond[HWSG_B_MIKE]     = hw_in.ext_mike_keyed;
      nxt_cond[HWSG_B_BATT]     = hw_in.ext_batt_low;
   end

   // Command decode; only these strobes reach the registers.
   wire do_wr   = cmd.valid & cmd.write;
   wire do_rd   = cmd.valid & ~cmd.write;
   wire wr_rise = do_wr & (cmd.sel == HWSG_SEL_RISE);
   wire wr_fall = do_wr & (cmd.sel == HWSG_SEL_FALL);
   wire wr_mask = do_wr & (cmd.sel == HWSG_SEL_MASK);
   // Reading the events is destructive, as is the clear-status command.
   wire ev_clr  = clear_status | (do_rd & (cmd.sel == HWSG_SEL_EVNT));

   // Read mux; an unknown select answers zero.
   always_comb begin
      unique case (cmd.sel)
         HWSG_SEL_COND: nxt_rdata = cond_ff;
         HWSG_SEL_RISE: nxt_rdata = rise_ff;
         HWSG_SEL_FALL: nxt_rdata = fall_ff;
         HWSG_SEL_EVNT: nxt_rdata = event_q;
         HWSG_SEL_MASK: nxt_rdata = mask_ff;
         default:       nxt_rdata = HWSG_ZERO;
      endcase
   end

   // The edge detector and event latch live in their own module.
   hwsg_edge #(
      .W (W)
   ) u_edge (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .cond     (cond_ff),
      .rise_flt (rise_ff),
      .fall_flt (fall_ff),
      .clear    (ev_clr),
      .event_q  (event_q)
   );

   // Condition sampling and writable registers.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cond_ff <= HWSG_ZERO;
         rise_ff <= HWSG_RST_RISE;
         fall_ff <= HWSG_RST_FALL;
         mask_ff <= HWSG_RST_MASK;
      end else if (clk_en) begin
         cond_ff <= nxt_cond;
         if (wr_rise) rise_ff <= cmd.wdata;
         if (wr_fall) fall_ff <= cmd.wdata;
         if (wr_mask) mask_ff <= cmd.wdata;
      end
   end

   // Query answer registered; event data is captured before it clears.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff  <= HWSG_ZERO;
         rvalid_ff <= 1'b0;
      end else if (clk_en) begin
         rvalid_ff <= do_rd;
         if (do_rd) rdata_ff <= nxt_rdata;
      end
   end

   assign rdata   = rdata_ff;
   assign rvalid  = rvalid_ff;
   // Summary is combinational from flops so it tracks the mask at once.
   assign summary = |(event_q & mask_ff);
endmodule
`default_nettype wire

// ---- hwsg_props.sv ----
// Assertions on the ports of the hardware status group.
`timescale 1ns/100ps
`default_nettype none
module hwsg_props
   import hwsg_pkg::*;
#(
   parameter int W = HWSG_W
) (
   input wire logic         core_clk,
   input wire logic         reset_n,
   input wire logic         clk_en,
   input wire hwsg_hw_in_t  hw_in,
   input wire hwsg_cmd_t    cmd,
   input wire logic         clear_status,
   input wire logic [W-1:0] rdata,
   input wire logic         rvalid,
   input wire logic         summary
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Taken reads and clears, and the encoder bits expected from raw inputs.
   wire logic rd  = clk_en && cmd.valid && !cmd.write;
   wire logic clr = rd && cmd.sel == HWSG_SEL_EVNT || clk_en && clear_status;
   wire logic b8  = &hw_in[9:7];
   wire logic b7  = !hw_in[6] && (hw_in[9] ? ^hw_in[8:7] : hw_in[8]);
   // The condition register lags the raw inputs by one enabled edge.
   sequence cond_rd;
      clk_en ##1 (rd && cmd.sel == HWSG_SEL_COND);
   endsequence
   // Inputs held still, so no fresh edge can land beside the clear.
   sequence cleared;
      (clk_en && $stable(hw_in)) [*2] ##1 clr;
   endsequence
   rd_answer_a: assert property (rd |=> rvalid)
      else $error("Read not answered.");
   spare_bits_a: assert property (cond_rd |=> !rdata[15] && !rdata[2])
      else $error("Spare condition bit set.");
   cond_map_a: assert property (cond_rd |=>
      rdata[14:9] == $past(hw_in[15:10], 2) &&
      rdata[6:3] == $past(hw_in[5:2], 2) && rdata[1:0] == $past(hw_in[1:0], 2))
      else $error("Condition bit wrong.");
   both_fields_a: assert property (cond_rd |=> rdata[8] == $past(b8, 2))
      else $error("Auxiliary field bit wrong.");
   one_field_a: assert property (cond_rd |=> rdata[7] == $past(b7, 2))
      else $error("Information field bit wrong.");
   evt_clear_a: assert property (
      cleared ##1 (rd && cmd.sel == HWSG_SEL_EVNT) |=> rdata == '0)
      else $error("Event register not cleared.");
   summary_clr_a: assert property (cleared |=> !summary)
      else $error("Summary after clear.");
   filt_back_a: assert property (
      (clk_en && cmd.valid && cmd.write && cmd.sel == HWSG_SEL_RISE) ##1
      (rd && cmd.sel == HWSG_SEL_RISE) |=> rdata == $past(cmd.wdata, 2))
      else $error("Filter readback wrong.");
endmodule
bind hwsg_top hwsg_props #(.W(W)) u_props (.core_clk, .reset_n, .clk_en,
   .hw_in, .cmd, .clear_status, .rdata, .rvalid, .summary);
`default_nettype wire

// ---- hwsg_ctrl.sv ----
// Remote controller model that issues status commands.
`timescale 1ns/100ps
`default_nettype none
module hwsg_ctrl
   import hwsg_pkg::*;
(
   input  wire logic      core_clk,
   output var  hwsg_cmd_t cmd,
   output var  logic      clear_status
);
   initial cmd = '0;
   initial clear_status = 1'b0;
   // One request held across one edge; a released bus shows inverted data.
   task automatic send(input logic v, wr, input logic [2:0] s,
                       input logic [15:0] d, input logic c, input int gap);
      cmd = '{v, wr, hwsg_sel_t'(s), d};
      clear_status = c;
      @(posedge core_clk);
      #1;
      if (gap > 0) begin
         cmd = '{1'b0, wr, cmd.sel, ~d};
         clear_status = 1'b0;
         repeat (gap) @(posedge core_clk);
         #1;
      end
   endtask
endmodule
`default_nettype wire

// ---- hwsg_top_bench.sv ----
// Self-checking bench for the hardware status group.
`timescale 1ns/100ps
`default_nettype none
module hwsg_top_bench
   import hwsg_pkg::*;
;
   logic           core_clk = 0, reset_n = 0, clk_en = 1;
   hwsg_hw_in_t    hw_in = '0;
   wire hwsg_cmd_t cmd;
   wire logic      clear_status;
   logic [15:0]    rdata, m_p, m_d, rg [8];
   logic           rvalid, summary, m_v;
   logic [31:0]    hs = 32'h45c303ef, cs = 32'h45c303ef;
   int             fail_count = 0, checked = 0, cyc = 0;
   hwsg_top dut (.core_clk, .reset_n, .clk_en, .hw_in, .cmd, .clear_status,
                 .rdata, .rvalid, .summary);
   hwsg_ctrl ctl (.core_clk, .cmd, .clear_status);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] got, exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checked %0d, fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial forever #4 core_clk = ~core_clk;
   // Inputs wander slowly so that quiet stretches occur; a hang is cut off.
   always @(posedge core_clk) begin
      #1 hs = lfsr(hs);
      clk_en = hs[4:2] != 3'h0;
      if (hs[1:0] == 2'h0) hw_in = hs[31:16];
      if (++cyc == 10000) begin
         fail_count++;
         report_and_stop;
      end
   end
   // Reference model: rg holds cond, rise, fall, event, mask, then spares.
   always @(posedge core_clk or negedge reset_n)
      if (!reset_n) begin
         rg = '{16'h0, HWSG_RST_RISE, HWSG_RST_FALL, HWSG_RST_EVNT,
                HWSG_RST_MASK, 16'h0, 16'h0, 16'h0};
         m_p = 16'h0;
         m_v = 1'b0;
      end else if (clk_en) begin
         m_v = cmd.valid && !cmd.write;
         if (m_v) m_d = rg[cmd.sel];
         if (m_v && cmd.sel == HWSG_SEL_EVNT || clear_status) rg[3] = 16'h0;
         rg[3] |= rg[1] & rg[0] & ~m_p | rg[2] & ~rg[0] & m_p;
         if (cmd.valid && cmd.write && cmd.sel inside {1, 2, 4})
            rg[cmd.sel] = cmd.wdata;
         m_p = rg[0];
         rg[0] = {1'b0, hw_in[15:10], &hw_in[9:7],
            ~hw_in[6] & (hw_in[9] ? ^hw_in[8:7] : hw_in[8]),
            hw_in[5:2], 1'b0, hw_in[1:0]};
      end
   // Results are compared mid-cycle, once the edge's updates have landed.
   always @(negedge core_clk)
      if (reset_n) begin
         chk({15'h0, rvalid}, {15'h0, m_v});
         if (m_v) chk(rdata, m_d);
         chk({15'h0, summary}, {15'h0, |(rg[3] & rg[4])});
      end
   initial begin
      repeat (2) @(posedge core_clk);
      #1 reset_n = 1;
      for (int s = 0; s < 8; s++) ctl.send(1, 0, 3'(s), 16'h0, 0, 0);
      for (int n = 0; n < 3000; n++) begin
         cs = lfsr(cs);
         ctl.send(cs[0], cs[1], cs[4:2], cs[31:16], &cs[6:5], cs[8:7] == 0);
         if (n == 1500) begin
            reset_n = 0;
            @(posedge core_clk);
            #1 reset_n = 1;
         end
      end
      ctl.send(0, 0, 0, 16'h0, 0, 1);
      report_and_stop;
   end
endmodule
`default_nettype wire
